//--- src/insn_decode_pkg.sv
// Package of constants and types for the instruction decoder and sequencer
// Behaviour
// - Every instruction is one 14-bit word
// - Destination bit 0 to accumulator, 1 to file
// - File address field spans 0x00 to 0x7f
// - Bit field picks one bit of byte
// - Literal is eight or eleven bits wide
// - Don't-care opcode bits decode the same either way; clear-accumulator x bits in port range set O_READ_PINS
// - One cycle, two when skip or branch
// - Instruction cycle is four oscillator phases
// - Bit field is position, file field is register
// - Port read-modify-write reads pin levels
// - Timer-zero write clears its assigned prescaler
// - Decrement-skip-zero skips when result is zero
// - Standby instruction enters standby, updates status flags
package insn_decode_pkg;
    localparam int INSN_W = 14;
    localparam int FILE_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int PHASES = 4;
    // Field positions
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int NIB_HI = 11;
    localparam int NIB_LO = 8;
    localparam int DEST_POS = 7;
    localparam int BIT_HI = 9;
    localparam int BIT_LO = 7;
    localparam int GOTO_POS = 11;
    // Opcode classes
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] CLASS_JUMP = 2'h2;
    localparam logic [1:0] CLASS_LIT = 2'h3;
    // Byte-class nibbles
    localparam logic [3:0] NIB_CTRL = 4'h0;
    localparam logic [3:0] NIB_CLR = 4'h1;
    localparam logic [3:0] NIB_DEC = 4'h3;
    localparam logic [3:0] NIB_DECSZ = 4'hb;
    localparam logic [3:0] NIB_INCSZ = 4'hf;
    // Bit-class sub-opcodes
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_TSTC = 2'h2;
    localparam logic [1:0] BOP_TSTS = 2'h3;
    // Literal-class sub-opcode of return-with-literal (bits 11:10)
    localparam logic [1:0] LOP_RETLW = 2'h1;
    // Fixed control words
    localparam logic [13:0] WORD_STANDBY = 14'h0063;
    localparam logic [13:0] WORD_CLRWDT = 14'h0064;
    localparam logic [13:0] WORD_RETURN = 14'h0008;
    localparam logic [13:0] WORD_RETFIE = 14'h0009;
    // Special file addresses
    localparam logic [6:0] ADDR_TIMER0 = 7'h01;
    localparam logic [6:0] ADDR_PORT_A = 7'h05;
    localparam logic [6:0] ADDR_PORT_D = 7'h09;
    // Reset values
    localparam logic [13:0] RST_INSN = 14'h0000;
    localparam logic [1:0] RST_PHASE = 2'h0;
    typedef enum logic [0:0] {
        SEQ_EXEC = 1'b0,
        SEQ_FILL = 1'b1
    } seq_state_t;
endpackage

//--- src/phase_gen.sv
// Four-phase instruction cycle divider
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
    input wire logic i_clk,
    input wire logic i_nrst,
    output logic [1:0] o_phase,
    output logic o_cycle_end
);
    import insn_decode_pkg::*;
    logic [1:0] phase_r; // Current phase
    logic [1:0] phase_nxt; // Next phase
    // Wraps every four oscillator periods
    always_comb begin
        phase_nxt = phase_r + 2'h1;
    end
    // Phase register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_r <= RST_PHASE;
        end else begin
            phase_r <= phase_nxt;
        end
    end
    assign o_phase = phase_r;
    assign o_cycle_end = (phase_r == 2'(PHASES - 1));
endmodule
`default_nettype wire

//--- src/insn_decoder.sv
// Instruction decoder and single/two-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module insn_decoder (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [insn_decode_pkg::INSN_W-1:0] I_INSN, // Fetched word, same clock
    input wire logic I_TEST_TRUE, // Skip test result from datapath, same clock
    input wire logic I_ZERO_RESULT, // ALU result is zero, same clock
    input wire logic I_PSA_TIMER0, // Prescaler assigned to timer zero
    output logic [1:0] O_PHASE,
    output logic O_CYCLE_END,
    output logic O_FETCH,
    output logic [1:0] O_CLASS,
    output logic [3:0] O_OPCODE,
    output logic [insn_decode_pkg::FILE_W-1:0] O_FILE_ADDR,
    output logic O_DEST_FILE,
    output logic O_WRITE_W,
    output logic O_WRITE_FILE,
    output logic [insn_decode_pkg::BIT_W-1:0] O_BIT_SEL,
    output logic [insn_decode_pkg::DATA_W-1:0] O_BIT_MASK,
    output logic O_BIT_SET,
    output logic O_BIT_CLR,
    output logic [insn_decode_pkg::LIT11_W-1:0] O_LITERAL,
    output logic O_LIT_WIDE,
    output logic O_PC_LOAD,
    output logic O_SKIP,
    output logic O_FILLER,
    output logic O_READ_PINS,
    output logic O_PRESCALE_CLR,
    output logic O_STANDBY,
    output logic O_WDT_CLR,
    output logic O_WATCHDOG_EXPIRED_FLAG_SET,
    output logic O_POWERDOWN_FLAG_CLR
);
    import insn_decode_pkg::*;

    // Shared bit-mask decode for bit-class operations
    function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] b);
        bit_mask = DATA_W'(8'h01 << b);
    endfunction

    // Port-register test, used for the pin-read decision
    function automatic logic is_port(input logic [FILE_W-1:0] a);
        is_port = (a >= ADDR_PORT_A) && (a <= ADDR_PORT_D);
    endfunction

    logic [1:0] phase; // Current phase
    logic cyc_end; // Last phase of cycle

    // Phase divider
    phase_gen u_phase (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .o_phase(phase),
        .o_cycle_end(cyc_end)
    );

    // Decoded fields, combinational from the fetched word
    logic [1:0] cls; // Class bits 13:12
    logic [3:0] nib; // Bits 11:8
    logic [FILE_W-1:0] faddr; // File field
    logic dbit; // Destination bit
    logic [BIT_W-1:0] bsel; // Bit number
    logic [1:0] bop; // Bit sub-opcode

    always_comb begin
        cls = I_INSN[CLASS_HI:CLASS_LO];
        nib = I_INSN[NIB_HI:NIB_LO];
        faddr = I_INSN[FILE_W-1:0];
        dbit = I_INSN[DEST_POS];
        bsel = I_INSN[BIT_HI:BIT_LO];
        bop = I_INSN[NIB_HI:BIT_HI+1];
    end

    // Sequencer and output state
    seq_state_t state_r, state_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic cyc_end_r, cyc_end_nxt;
    logic fetch_r, fetch_nxt;
    logic [1:0] class_r, class_nxt;
    logic [3:0] opc_r, opc_nxt;
    logic [FILE_W-1:0] faddr_r, faddr_nxt;
    logic dest_r, dest_nxt;
    logic wr_w_r, wr_w_nxt;
    logic wr_f_r, wr_f_nxt;
    logic [BIT_W-1:0] bsel_r, bsel_nxt;
    logic [DATA_W-1:0] mask_r, mask_nxt;
    logic bset_r, bset_nxt;
    logic bclr_r, bclr_nxt;
    logic [LIT11_W-1:0] lit_r, lit_nxt;
    logic litw_r, litw_nxt;
    logic pcl_r, pcl_nxt;
    logic skip_r, skip_nxt;
    logic fill_r, fill_nxt;
    logic pins_r, pins_nxt;
    logic psc_r, psc_nxt;
    logic stby_r, stby_nxt;
    logic wdt_r, wdt_nxt;
    logic to_r, to_nxt;
    logic pd_r, pd_nxt;
    logic two_cycle; // Current word needs a filler cycle
    logic writes_file; // Current word writes file register
    logic is_skip_op; // Conditional skip instruction

    // Next-value logic; decode is latched once per instruction cycle
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase;
        cyc_end_nxt = cyc_end;
        fetch_nxt = 1'b0;
        class_nxt = class_r;
        opc_nxt = opc_r;
        faddr_nxt = faddr_r;
        dest_nxt = dest_r;
        wr_w_nxt = wr_w_r;
        wr_f_nxt = wr_f_r;
        bsel_nxt = bsel_r;
        mask_nxt = mask_r;
        bset_nxt = bset_r;
        bclr_nxt = bclr_r;
        lit_nxt = lit_r;
        litw_nxt = litw_r;
        pcl_nxt = pcl_r;
        skip_nxt = skip_r;
        fill_nxt = fill_r;
        pins_nxt = pins_r;
        psc_nxt = psc_r;
        stby_nxt = 1'b0;
        wdt_nxt = 1'b0;
        to_nxt = 1'b0;
        pd_nxt = 1'b0;
        two_cycle = 1'b0;
        writes_file = 1'b0;
        is_skip_op = 1'b0;
        if (cls == CLASS_BYTE) begin
            is_skip_op = (nib == NIB_DECSZ) || (nib == NIB_INCSZ);
        end else if (cls == CLASS_BIT) begin
            is_skip_op = bop[1];
        end
        if (cyc_end) begin
            fetch_nxt = 1'b1; // Next word fetched at cycle boundary
            case (state_r)
                SEQ_EXEC: begin
                    fill_nxt = 1'b0;
                    class_nxt = cls;
                    opc_nxt = nib;
                    faddr_nxt = faddr;
                    bsel_nxt = bsel;
                    mask_nxt = bit_mask(bsel);
                    dest_nxt = 1'b0;
                    wr_w_nxt = 1'b0;
                    wr_f_nxt = 1'b0;
                    bset_nxt = 1'b0;
                    bclr_nxt = 1'b0;
                    lit_nxt = {{(LIT11_W-LIT8_W){1'b0}}, I_INSN[LIT8_W-1:0]};
                    litw_nxt = 1'b0;
                    pcl_nxt = 1'b0;
                    skip_nxt = 1'b0;
                    case (cls)
                        CLASS_BYTE: begin
                            if (nib == NIB_CTRL && !dbit) begin
                                // Control words; x positions of the nop are ignored
                                pcl_nxt = (I_INSN == WORD_RETURN) || (I_INSN == WORD_RETFIE);
                                stby_nxt = (I_INSN == WORD_STANDBY);
                                to_nxt = (I_INSN == WORD_STANDBY) || (I_INSN == WORD_CLRWDT);
                                pd_nxt = (I_INSN == WORD_STANDBY);
                                wdt_nxt = (I_INSN == WORD_STANDBY) || (I_INSN == WORD_CLRWDT);
                            end else if (nib == NIB_CTRL || nib == NIB_CLR) begin
                                // Move-to-file / clear: d bit selects file or accumulator
                                dest_nxt = dbit;
                                wr_f_nxt = dbit;
                                wr_w_nxt = !dbit; // Clear-accumulator; low 7 bits are x
                                writes_file = dbit;
                            end else begin
                                dest_nxt = dbit;
                                wr_f_nxt = dbit;
                                wr_w_nxt = !dbit;
                                writes_file = dbit;
                            end
                            pins_nxt = is_port(faddr);
                        end
                        CLASS_BIT: begin
                            bset_nxt = (bop == BOP_SET);
                            bclr_nxt = (bop == BOP_CLR);
                            wr_f_nxt = !bop[1];
                            dest_nxt = !bop[1];
                            writes_file = !bop[1];
                            pins_nxt = is_port(faddr);
                        end
                        CLASS_JUMP: begin
                            lit_nxt = I_INSN[LIT11_W-1:0];
                            litw_nxt = 1'b1;
                            pcl_nxt = 1'b1;
                        end
                        default: begin
                            // Literal class; bits marked x ignored by using only 11:10
                            wr_w_nxt = 1'b1;
                            pcl_nxt = (I_INSN[NIB_HI:NIB_HI-1] == LOP_RETLW);
                            pins_nxt = 1'b0;
                        end
                    endcase
                    psc_nxt = writes_file && (faddr == ADDR_TIMER0) && I_PSA_TIMER0;
                    two_cycle = pcl_nxt || (is_skip_op && I_TEST_TRUE);
                    skip_nxt = is_skip_op && I_TEST_TRUE;
                    if (two_cycle) begin
                        state_nxt = SEQ_FILL;
                    end
                end
                SEQ_FILL: begin
                    // Prefetched word dropped; nothing written
                    fill_nxt = 1'b1;
                    wr_w_nxt = 1'b0;
                    wr_f_nxt = 1'b0;
                    bset_nxt = 1'b0;
                    bclr_nxt = 1'b0;
                    pcl_nxt = 1'b0;
                    skip_nxt = 1'b0;
                    psc_nxt = 1'b0;
                    pins_nxt = 1'b0;
                    state_nxt = SEQ_EXEC;
                end
                default: begin
                    state_nxt = SEQ_EXEC;
                end
            endcase
        end
    end

    // Zero-result input unused here: skip test arrives pre-evaluated
    logic unused_zero;
    assign unused_zero = I_ZERO_RESULT;

    // Registers only
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_r <= SEQ_EXEC;
            phase_r <= RST_PHASE;
            cyc_end_r <= 1'b0;
            fetch_r <= 1'b0;
            class_r <= 2'h0;
            opc_r <= 4'h0;
            faddr_r <= 7'h00;
            dest_r <= 1'b1; // Default destination is file
            wr_w_r <= 1'b0;
            wr_f_r <= 1'b0;
            bsel_r <= 3'h0;
            mask_r <= 8'h00;
            bset_r <= 1'b0;
            bclr_r <= 1'b0;
            lit_r <= 11'h000;
            litw_r <= 1'b0;
            pcl_r <= 1'b0;
            skip_r <= 1'b0;
            fill_r <= 1'b0;
            pins_r <= 1'b0;
            psc_r <= 1'b0;
            stby_r <= 1'b0;
            wdt_r <= 1'b0;
            to_r <= 1'b0;
            pd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            cyc_end_r <= cyc_end_nxt;
            fetch_r <= fetch_nxt;
            class_r <= class_nxt;
            opc_r <= opc_nxt;
            faddr_r <= faddr_nxt;
            dest_r <= dest_nxt;
            wr_w_r <= wr_w_nxt;
            wr_f_r <= wr_f_nxt;
            bsel_r <= bsel_nxt;
            mask_r <= mask_nxt;
            bset_r <= bset_nxt;
            bclr_r <= bclr_nxt;
            lit_r <= lit_nxt;
            litw_r <= litw_nxt;
            pcl_r <= pcl_nxt;
            skip_r <= skip_nxt;
            fill_r <= fill_nxt;
            pins_r <= pins_nxt;
            psc_r <= psc_nxt;
            stby_r <= stby_nxt;
            wdt_r <= wdt_nxt;
            to_r <= to_nxt;
            pd_r <= pd_nxt;
        end
    end

    assign O_PHASE = phase_r;
    assign O_CYCLE_END = cyc_end_r;
    assign O_FETCH = fetch_r;
    assign O_CLASS = class_r;
    assign O_OPCODE = opc_r;
    assign O_FILE_ADDR = faddr_r;
    assign O_DEST_FILE = dest_r;
    assign O_WRITE_W = wr_w_r;
    assign O_WRITE_FILE = wr_f_r;
    assign O_BIT_SEL = bsel_r;
    assign O_BIT_MASK = mask_r;
    assign O_BIT_SET = bset_r;
    assign O_BIT_CLR = bclr_r;
    assign O_LITERAL = lit_r;
    assign O_LIT_WIDE = litw_r;
    assign O_PC_LOAD = pcl_r;
    assign O_SKIP = skip_r;
    assign O_FILLER = fill_r;
    assign O_READ_PINS = pins_r;
    assign O_PRESCALE_CLR = psc_r;
    assign O_STANDBY = stby_r;
    assign O_WDT_CLR = wdt_r;
    assign O_WATCHDOG_EXPIRED_FLAG_SET = to_r;
    assign O_POWERDOWN_FLAG_CLR = pd_r;
endmodule
`default_nettype wire

//--- test/fetch_model.sv
// Program memory fetch side model feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module fetch_model
    import insn_decode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_fetch,
    input wire logic [INSN_W-1:0] i_next,
    output logic [INSN_W-1:0] o_insn
);
    // Next word loaded on the edge that sees the fetch pulse, so it is stable well before the boundary
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_insn <= RST_INSN;
        end else if (i_fetch) begin
            o_insn <= i_next;
        end
    end
endmodule
`default_nettype wire

//--- test/insn_decoder_sva.sv
// Port-level timing and decode checks for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module insn_decoder_chk
    import insn_decode_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [1:0] O_PHASE,
    input wire logic O_FETCH,
    input wire logic [1:0] O_CLASS,
    input wire logic [3:0] O_OPCODE,
    input wire logic O_DEST_FILE,
    input wire logic O_WRITE_W,
    input wire logic O_WRITE_FILE,
    input wire logic [BIT_W-1:0] O_BIT_SEL,
    input wire logic [DATA_W-1:0] O_BIT_MASK,
    input wire logic O_BIT_SET,
    input wire logic O_BIT_CLR,
    input wire logic [LIT11_W-1:0] O_LITERAL,
    input wire logic O_LIT_WIDE,
    input wire logic O_PC_LOAD,
    input wire logic O_SKIP,
    input wire logic O_FILLER
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    // Phase walk after the last phase
    sequence phase_wrap;
        O_PHASE == 2'h0 ##1 O_PHASE == 2'h1 ##1 O_PHASE == 2'h2 ##1 O_PHASE == 2'h3;
    endsequence
    // Quiet gap between fetch pulses
    sequence fetch_gap;
        !O_FETCH [*3] ##1 O_FETCH;
    endsequence
    chk_phase_order: assert property (O_PHASE == 2'h3 |=> phase_wrap)
        else $error("phase did not step through four values");
    chk_fetch_gap: assert property ($rose(O_FETCH) |=> fetch_gap)
        else $error("fetch pulses not four cycles apart");
    chk_skip_fill: assert property (O_FETCH && !O_FILLER && (O_SKIP || O_PC_LOAD) |=> ##3 O_FETCH && O_FILLER)
        else $error("no filler cycle after skip or branch");
    chk_fill_once: assert property (O_FETCH && O_FILLER |-> ##4 O_FETCH && !O_FILLER)
        else $error("filler lasted more than one cycle");
    chk_filler_quiet: assert property (O_FILLER |-> !(O_WRITE_W || O_WRITE_FILE || O_PC_LOAD || O_BIT_SET || O_BIT_CLR))
        else $error("write during filler cycle");
    chk_dest_route: assert property (O_FETCH && !O_FILLER && O_CLASS == CLASS_BYTE && O_OPCODE != NIB_CTRL
        |-> O_WRITE_FILE == O_DEST_FILE && O_WRITE_W == !O_DEST_FILE)
        else $error("result target disagrees with destination bit");
    chk_bit_mask: assert property (O_FETCH && !O_FILLER && O_CLASS == CLASS_BIT |-> O_BIT_MASK == 8'h01 << O_BIT_SEL)
        else $error("bit mask does not match bit number");
    chk_lit_width: assert property (O_FETCH && !O_FILLER && O_CLASS == CLASS_LIT |-> !O_LIT_WIDE && O_LITERAL[10:8] == 3'h0)
        else $error("short literal not eight bits");
endmodule
bind insn_decoder insn_decoder_chk u_chk (.I_CLK, .I_NRST, .O_PHASE, .O_FETCH, .O_CLASS, .O_OPCODE, .O_DEST_FILE,
    .O_WRITE_W, .O_WRITE_FILE, .O_BIT_SEL, .O_BIT_MASK, .O_BIT_SET, .O_BIT_CLR, .O_LITERAL, .O_LIT_WIDE,
    .O_PC_LOAD, .O_SKIP, .O_FILLER);
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import insn_decode_pkg::*;
    logic I_CLK = 1'b0;
    logic I_NRST = 1'b0;
    logic I_TEST_TRUE = 1'b0;
    logic I_PSA_TIMER0 = 1'b0;
    logic I_ZERO_RESULT = 1'b0;
    logic [INSN_W-1:0] I_INSN;
    logic [INSN_W-1:0] nxt = 14'h0000;
    logic [1:0] O_PHASE, O_CLASS;
    logic [3:0] O_OPCODE;
    logic [FILE_W-1:0] O_FILE_ADDR;
    logic [BIT_W-1:0] O_BIT_SEL;
    logic [DATA_W-1:0] O_BIT_MASK;
    logic [LIT11_W-1:0] O_LITERAL;
    logic O_CYCLE_END, O_FETCH, O_DEST_FILE, O_WRITE_W, O_WRITE_FILE, O_BIT_SET, O_BIT_CLR, O_LIT_WIDE;
    logic O_PC_LOAD, O_SKIP, O_FILLER, O_READ_PINS, O_PRESCALE_CLR, O_STANDBY, O_WDT_CLR;
    logic O_WATCHDOG_EXPIRED_FLAG_SET, O_POWERDOWN_FLAG_CLR;
    int errors = 0;
    int n_compared = 0;
    // 200 MHz clock
    always #2.5 I_CLK = ~I_CLK;
    insn_decoder DUT (.*);
    fetch_model u_mem (.i_clk(I_CLK), .i_nrst(I_NRST), .i_fetch(O_FETCH), .i_next(nxt), .o_insn(I_INSN));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Next fetch pulse at a falling edge, bounded
    task automatic wait_fetch(output int n);
        n = 0;
        do begin
            @(negedge I_CLK);
            n++;
        end while (O_FETCH !== 1'b1 && n < 40);
    endtask
    // One word through the decoder; returns with its decode visible
    task automatic issue(input logic [13:0] w, input logic t, input logic p);
        int n;
        nxt = w;
        I_TEST_TRUE = t;
        I_PSA_TIMER0 = p;
        wait_fetch(n);
        chk("fetch gap", 16'(n), 16'h4);
        chk("last phase", 16'({O_PHASE, O_CYCLE_END}), 16'({2'(PHASES - 1), 1'b1}));
    endtask
    // Reset held six cycles; default destination is file
    task automatic do_reset();
        int n;
        I_NRST = 1'b0;
        repeat (6) @(negedge I_CLK);
        chk("reset outs", 16'({O_DEST_FILE, O_FETCH, O_PC_LOAD, O_FILLER}), 16'h8);
        I_NRST = 1'b1;
        wait_fetch(n);
        chk("first fetch", 16'(n), 16'(PHASES));
    endtask
    task automatic byte_ops();
        for (int i = 0; i < 4; i++) begin
            issue({CLASS_BYTE, NIB_DEC, i[0], i[1] ? 7'h7f : 7'h00}, 1'b0, 1'b0);
            chk("class/op", 16'({O_CLASS, O_OPCODE}), 16'({CLASS_BYTE, NIB_DEC}));
            chk("file addr", 16'(O_FILE_ADDR), i[1] ? 16'h7f : 16'h0);
            chk("target", 16'({O_WRITE_FILE, O_WRITE_W}), i[0] ? 16'h2 : 16'h1);
        end
    endtask
    // Every bit op and bit number
    task automatic bit_ops();
        for (int i = 0; i < 32; i++) begin
            issue({CLASS_BIT, i[4:3], i[2:0], 7'(i + 16)}, 1'b0, 1'b0);
            chk("bit sel", 16'(O_BIT_SEL), 16'(i[2:0]));
            chk("bit mask", 16'(O_BIT_MASK), 16'(8'h01 << i[2:0]));
            chk("file addr", 16'(O_FILE_ADDR), 16'(i + 16));
            chk("set/clr", 16'({O_BIT_SET, O_BIT_CLR}), 16'({i[4:3] == BOP_SET, i[4:3] == BOP_CLR}));
            chk("skip", 16'(O_SKIP), 16'h0);
        end
    endtask
    // Short literal and no-op with every don't-care pattern
    task automatic literal_ops();
        for (int x = 0; x < 4; x++) begin
            issue({CLASS_LIT, 2'h0, 2'(x), 8'ha5}, 1'b0, 1'b0);
            chk("literal", 16'({O_LIT_WIDE, O_LITERAL}), 16'h00a5);
            chk("to accum", 16'(O_WRITE_W), 16'h1);
            issue({CLASS_BYTE, NIB_CLR, 1'b0, 7'(x * 37)}, 1'b0, 1'b0);
            chk("clear accum", 16'({O_WRITE_W, O_WRITE_FILE, O_DEST_FILE}), 16'h4);
            issue(14'(x) << 5, 1'b0, 1'b0);
            chk("nop outs", 16'({O_WRITE_W, O_WRITE_FILE, O_PC_LOAD, O_SKIP}), 16'h0);
        end
    endtask
    // Returns, each followed by a nop, then call and jump, each followed by a discarded write
    task automatic jump_ops();
        logic [13:0] r [3] = '{{CLASS_LIT, LOP_RETLW, 2'h3, 8'h3c}, WORD_RETURN, WORD_RETFIE};
        for (int i = 0; i < 3; i++) begin
            issue(r[i], 1'b0, 1'b0);
            chk("return", 16'({O_PC_LOAD, O_FILLER, O_LIT_WIDE}), 16'h4);
            issue(14'h0000, 1'b0, 1'b0);
            chk("return fill", 16'({O_FILLER, O_PC_LOAD}), 16'h2);
        end
        for (int i = 0; i < 2; i++) begin
            issue({CLASS_JUMP, i[0], 11'h5a3}, 1'b0, 1'b0);
            chk("wide literal", 16'({O_PC_LOAD, O_LIT_WIDE, O_LITERAL}), 16'h1da3);
            issue({CLASS_BYTE, NIB_CLR, 1'b1, 7'h20}, 1'b0, 1'b0);
            chk("filler", 16'({O_FILLER, O_WRITE_W, O_WRITE_FILE, O_PC_LOAD}), 16'h8);
        end
    endtask
    // Taken skip first, then a plain decrement that the filler drops when the skip is taken
    task automatic skip_ops();
        for (int t = 3; t >= 0; t--) begin
            issue({CLASS_BYTE, t[1] ? NIB_INCSZ : NIB_DECSZ, 1'b1, 7'h30}, t[0], 1'b0);
            chk("skip", 16'({O_SKIP, O_WRITE_FILE, O_FILLER}), t[0] ? 16'h6 : 16'h2);
            issue({CLASS_BYTE, NIB_DEC, 1'b0, 7'h30}, 1'b0, 1'b0);
            chk("after skip", 16'({O_FILLER, O_WRITE_W}), t[0] ? 16'h2 : 16'h1);
        end
        issue({CLASS_BIT, BOP_TSTS, 3'h5, 7'h22}, 1'b1, 1'b0);
        chk("bit skip", 16'({O_SKIP, O_WRITE_FILE, O_BIT_SET, O_BIT_CLR}), 16'h8);
        issue({CLASS_BIT, BOP_SET, 3'h5, 7'h22}, 1'b0, 1'b0);
        chk("bit skip fill", 16'({O_FILLER, O_BIT_SET}), 16'h2);
    endtask
    // Port read-back and timer prescaler clear at range edges
    task automatic port_timer();
        logic [6:0] a [6] = '{7'h04, 7'h05, 7'h07, 7'h09, 7'h0a, 7'h01};
        for (int i = 0; i < 6; i++) begin
            issue({CLASS_BYTE, 4'h8, 1'b1, a[i]}, 1'b0, 1'b1);
            chk("read pins", 16'(O_READ_PINS), 16'(a[i] inside {[7'h05:7'h09]}));
            chk("prescale clr", 16'(O_PRESCALE_CLR), 16'(a[i] == ADDR_TIMER0));
        end
        issue({CLASS_BYTE, NIB_CTRL, 1'b1, ADDR_TIMER0}, 1'b0, 1'b0);
        chk("prescale clr", 16'(O_PRESCALE_CLR), 16'h0);
    endtask
    // Standby then watchdog clear
    task automatic standby_ops();
        issue(WORD_STANDBY, 1'b0, 1'b0);
        chk("standby", 16'({O_STANDBY, O_WATCHDOG_EXPIRED_FLAG_SET, O_POWERDOWN_FLAG_CLR, O_WDT_CLR}), 16'hf);
        issue(WORD_CLRWDT, 1'b0, 1'b0);
        chk("wdt clear", 16'({O_STANDBY, O_WDT_CLR, O_WATCHDOG_EXPIRED_FLAG_SET, O_POWERDOWN_FLAG_CLR}), 16'h6);
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        byte_ops();
        bit_ops();
        literal_ops();
        jump_ops();
        skip_ops();
        port_timer();
        standby_ops();
        do_reset();
        byte_ops();
        test_done();
    end
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #20000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
